/* pdeo_top.sv */
`timescale 1ns/10ps
// Function
// - port D bit 0 feeds synced pin to capture input, no overrides.
// - port D bit 1 feeds interrupt 0; enable forces input buffer on.
// - clock-out fuse makes port E bit 7 output divided clock, ignoring registers.
// - divided clock keeps leaving port E bit 7 during reset.
// - each port E pin-change mask with group enable forces input buffer on.
// - three-wire mode drives port E bit 6 value from serial data out.
// - two-wire mode: bit 5 pull-up off, drives 0 open drain.
// - two-wire mode: bit 4 open drain, clock hold, toggle strobe.
// - start-condition enable keeps bits 5 and 4 input buffers on.
// - synchronous mode: bit 2 direction picks clock out or in.
// - external serial clock active only in synchronous mode.
// - transmitter on: bit 1 pull-up off, output, drives transmit data.
// - receiver on: bit 0 forced input, feeds receiver data.
// - receiver forced input: pull-up is port bit and not global disable.
// - bits 3 and 2 feed comparator; disable bit turns buffer off unless pin-change sensing is on for that bit.
module pdeo_top (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] port_d_pin_in,
  input  wire logic [7:0] port_d_out,
  input  wire logic [7:0] port_d_dir,
  input  wire logic [7:0] port_e_pin_in,
  input  wire logic [7:0] port_e_out,
  input  wire logic [7:0] port_e_dir,
  input  wire logic       global_pullup_off,
  input  wire logic       ext_int0_en,
  input  wire logic       clock_out_fuse,
  input  wire logic       io_clock_div,
  input  wire logic [7:0] pin_change_mask,
  input  wire logic       pin_change_group0_en,
  input  wire logic       three_wire_mode_sel,
  input  wire logic       two_wire_mode_sel,
  input  wire logic       serial_if_data_out,
  input  wire logic       clock_hold_low,
  input  wire logic       clock_toggle_strobe,
  input  wire logic       start_cond_irq_en,
  input  wire logic       serial_sync_mode,
  input  wire logic       serial_ext_clock_out,
  input  wire logic       transmitter_on,
  input  wire logic       transmit_data,
  input  wire logic       receiver_on,
  input  wire logic       neg_in_digital_disable,
  input  wire logic       pos_in_digital_disable,
  output logic [7:0]      port_d_pullup_on,
  output logic [7:0]      port_d_drive_en,
  output logic [7:0]      port_d_drive_val,
  output logic [7:0]      port_d_input_buf_on,
  output logic [7:0]      port_d_in_sync,
  output logic [7:0]      port_e_pullup_on,
  output logic [7:0]      port_e_drive_en,
  output logic [7:0]      port_e_drive_val,
  output logic [7:0]      port_e_toggle_req,
  output logic [7:0]      port_e_input_buf_on,
  output logic [7:0]      port_e_in_sync,
  output logic            capture_input,
  output logic            ext_int0_input,
  output logic [7:0]      pin_change_input,
  output logic            serial_if_data_in,
  output logic            serial_if_clock,
  output logic            serial_ext_clock_in,
  output logic            serial_ext_clock_drive,
  output logic            receive_data_in,
  output logic            comparator_neg_sel,
  output logic            comparator_pos_sel,
  output logic            divided_clock_out
);
  pdeo_ovr_if d_bus ();
  pdeo_ovr_if e_bus ();

  pdeo_pkg::pdeo_ovr_type d_ovr;
  pdeo_pkg::pdeo_ovr_type e_ovr;
  logic [7:0]             d_sync;
  logic [7:0]             e_sync;
  logic [7:0]             pc_sense;

  pdeo_pin_sync u_sync_d (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (port_d_pin_in),
    .pin_sync (d_sync)
  );

  pdeo_pin_sync u_sync_e (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (port_e_pin_in),
    .pin_sync (e_sync)
  );

  assign pc_sense = pin_change_mask & {pdeo_pkg::PORT_WIDTH{pin_change_group0_en}};

  // port D: only bit 1 overrides anything
  always_comb begin
    d_ovr = '0;
    d_ovr.input_enable_ovr_en[pdeo_pkg::BIT_EXT_INT0]  = ext_int0_en;
    d_ovr.input_enable_ovr_val[pdeo_pkg::BIT_EXT_INT0] = ext_int0_en;
  end

  always_comb begin
    e_ovr = '0;
    // pin-change sensing on every bit; bits 5..4 and 3..2 refine below
    e_ovr.input_enable_ovr_en  = pc_sense;
    e_ovr.input_enable_ovr_val = 8'hff;

    // bit 7: divided clock, the fuse is not a reset-gated signal
    e_ovr.direction_ovr_en[pdeo_pkg::BIT_CLK_OUT]  = clock_out_fuse;
    e_ovr.direction_ovr_val[pdeo_pkg::BIT_CLK_OUT] = 1'b1;
    e_ovr.outvalue_ovr_en[pdeo_pkg::BIT_CLK_OUT]   = clock_out_fuse;
    e_ovr.outvalue_ovr_val[pdeo_pkg::BIT_CLK_OUT]  = io_clock_div;

    // bit 6: three-wire data out
    e_ovr.outvalue_ovr_en[pdeo_pkg::BIT_SER_DOUT]  = three_wire_mode_sel;
    e_ovr.outvalue_ovr_val[pdeo_pkg::BIT_SER_DOUT] = serial_if_data_out;

    // bit 5: two-wire data, drive low only while data or port bit is low
    e_ovr.pullup_ovr_en[pdeo_pkg::BIT_SER_DATA]     = two_wire_mode_sel;
    e_ovr.direction_ovr_en[pdeo_pkg::BIT_SER_DATA]  = two_wire_mode_sel;
    e_ovr.direction_ovr_val[pdeo_pkg::BIT_SER_DATA] =
      ~(serial_if_data_out & port_e_out[pdeo_pkg::BIT_SER_DATA])
      & port_e_dir[pdeo_pkg::BIT_SER_DATA];
    e_ovr.outvalue_ovr_en[pdeo_pkg::BIT_SER_DATA]   =
      two_wire_mode_sel & port_e_dir[pdeo_pkg::BIT_SER_DATA];

    // bit 4: two-wire clock, hold stretches it low
    e_ovr.pullup_ovr_en[pdeo_pkg::BIT_SER_CLK]     = two_wire_mode_sel;
    e_ovr.direction_ovr_en[pdeo_pkg::BIT_SER_CLK]  = two_wire_mode_sel;
    e_ovr.direction_ovr_val[pdeo_pkg::BIT_SER_CLK] =
      (clock_hold_low | ~port_e_out[pdeo_pkg::BIT_SER_CLK])
      & port_e_dir[pdeo_pkg::BIT_SER_CLK];
    e_ovr.outvalue_ovr_en[pdeo_pkg::BIT_SER_CLK]   =
      two_wire_mode_sel & port_e_dir[pdeo_pkg::BIT_SER_CLK];
    e_ovr.toggle_ovr_en[pdeo_pkg::BIT_SER_CLK]     = clock_toggle_strobe;

    // start detector must see both lines even with pin change off
    e_ovr.input_enable_ovr_en[pdeo_pkg::BIT_SER_DATA] =
      pc_sense[pdeo_pkg::BIT_SER_DATA] | start_cond_irq_en;
    e_ovr.input_enable_ovr_en[pdeo_pkg::BIT_SER_CLK]  =
      pc_sense[pdeo_pkg::BIT_SER_CLK] | start_cond_irq_en;

    // bits 3..2: analog inputs; pin change beats the disable bit
    e_ovr.input_enable_ovr_en[pdeo_pkg::BIT_NEG_IN]   =
      pc_sense[pdeo_pkg::BIT_NEG_IN] | neg_in_digital_disable;
    e_ovr.input_enable_ovr_val[pdeo_pkg::BIT_NEG_IN]  = pc_sense[pdeo_pkg::BIT_NEG_IN];
    e_ovr.input_enable_ovr_en[pdeo_pkg::BIT_POS_IN]   =
      pc_sense[pdeo_pkg::BIT_POS_IN] | pos_in_digital_disable;
    e_ovr.input_enable_ovr_val[pdeo_pkg::BIT_POS_IN]  = pc_sense[pdeo_pkg::BIT_POS_IN];

    // bit 2 pull-up override follows external clock output enable
    e_ovr.pullup_ovr_en[pdeo_pkg::BIT_POS_IN]  = serial_ext_clock_drive;
    e_ovr.pullup_ovr_val[pdeo_pkg::BIT_POS_IN] = serial_ext_clock_out;

    // bit 1: transmitter
    e_ovr.pullup_ovr_en[pdeo_pkg::BIT_TXD]     = transmitter_on;
    e_ovr.direction_ovr_en[pdeo_pkg::BIT_TXD]  = transmitter_on;
    e_ovr.direction_ovr_val[pdeo_pkg::BIT_TXD] = 1'b1;
    e_ovr.outvalue_ovr_en[pdeo_pkg::BIT_TXD]   = transmitter_on;
    e_ovr.outvalue_ovr_val[pdeo_pkg::BIT_TXD]  = transmit_data;

    // bit 0: receiver forces input, pull-up still from port bit
    e_ovr.pullup_ovr_en[pdeo_pkg::BIT_RXD]    = receiver_on;
    e_ovr.pullup_ovr_val[pdeo_pkg::BIT_RXD]   =
      port_e_out[pdeo_pkg::BIT_RXD] & ~global_pullup_off;
    e_ovr.direction_ovr_en[pdeo_pkg::BIT_RXD] = receiver_on;
  end

  assign d_bus.ovr               = d_ovr;
  assign d_bus.port_out          = port_d_out;
  assign d_bus.port_dir          = port_d_dir;
  assign d_bus.global_pullup_off = global_pullup_off;
  assign e_bus.ovr               = e_ovr;
  assign e_bus.port_out          = port_e_out;
  assign e_bus.port_dir          = port_e_dir;
  assign e_bus.global_pullup_off = global_pullup_off;

  pdeo_pin_apply u_apply_d (
    .bus          (d_bus),
    .pullup_on    (port_d_pullup_on),
    .drive_en     (port_d_drive_en),
    .drive_val    (port_d_drive_val),
    .toggle_req   (),
    .input_buf_on (port_d_input_buf_on)
  );

  pdeo_pin_apply u_apply_e (
    .bus          (e_bus),
    .pullup_on    (port_e_pullup_on),
    .drive_en     (port_e_drive_en),
    .drive_val    (port_e_drive_val),
    .toggle_req   (port_e_toggle_req),
    .input_buf_on (port_e_input_buf_on)
  );

  assign port_d_in_sync = d_sync;
  assign port_e_in_sync = e_sync;

  // peripheral inputs take the synced pins, never the raw ones
  assign capture_input     = d_sync[pdeo_pkg::BIT_CAPTURE];
  assign ext_int0_input    = d_sync[pdeo_pkg::BIT_EXT_INT0];
  assign pin_change_input  = e_sync;
  assign serial_if_data_in = e_sync[pdeo_pkg::BIT_SER_DATA];
  assign serial_if_clock   = e_sync[pdeo_pkg::BIT_SER_CLK];
  assign receive_data_in   = e_sync[pdeo_pkg::BIT_RXD];

  // external clock role only exists in synchronous mode
  assign serial_ext_clock_drive = serial_sync_mode & port_e_dir[pdeo_pkg::BIT_POS_IN];
  assign serial_ext_clock_in    = serial_sync_mode & ~port_e_dir[pdeo_pkg::BIT_POS_IN]
                                & e_sync[pdeo_pkg::BIT_POS_IN];

  // analog path is a direct wire; these flags only say the pins are tapped
  assign comparator_neg_sel = 1'b1;
  assign comparator_pos_sel = 1'b1;

  // clock leaves regardless of rst_n since the path is purely combinational
  assign divided_clock_out = clock_out_fuse & io_clock_div;
endmodule // pdeo_top

/* pdeo_pkg.sv */
package pdeo_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int BIT_CAPTURE = 0;
  localparam int BIT_EXT_INT0 = 1;
  localparam int BIT_POS_IN = 2;
  localparam int BIT_NEG_IN = 3;
  localparam int BIT_SER_CLK = 4;
  localparam int BIT_SER_DATA = 5;
  localparam int BIT_SER_DOUT = 6;
  localparam int BIT_CLK_OUT = 7;
  localparam int BIT_RXD = 0;
  localparam int BIT_TXD = 1;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef struct packed {
    logic [7:0] pullup_ovr_en;
    logic [7:0] pullup_ovr_val;
    logic [7:0] direction_ovr_en;
    logic [7:0] direction_ovr_val;
    logic [7:0] outvalue_ovr_en;
    logic [7:0] outvalue_ovr_val;
    logic [7:0] toggle_ovr_en;
    logic [7:0] input_enable_ovr_en;
    logic [7:0] input_enable_ovr_val;
  } pdeo_ovr_type;
endpackage

/* pdeo_ovr_if.sv */
`timescale 1ns/10ps
interface pdeo_ovr_if;
  pdeo_pkg::pdeo_ovr_type ovr;
  logic [7:0]             port_out;
  logic [7:0]             port_dir;
  logic                   global_pullup_off;
  modport src (output ovr, input port_out, input port_dir, input global_pullup_off);
  modport sink (input ovr, input port_out, input port_dir, input global_pullup_off);
endinterface

/* pdeo_pin_apply.sv */
`timescale 1ns/10ps
module pdeo_pin_apply (
  pdeo_ovr_if.sink   bus,
  output logic [7:0] pullup_on,
  output logic [7:0] drive_en,
  output logic [7:0] drive_val,
  output logic [7:0] toggle_req,
  output logic [7:0] input_buf_on
);
  // per-pin mux: override value replaces the register value while enabled
  for (genvar i = 0; i < pdeo_pkg::PORT_WIDTH; i++) begin : g_pin
    always_comb begin
      pullup_on[i] = bus.ovr.pullup_ovr_en[i] ? bus.ovr.pullup_ovr_val[i]
                   : (bus.port_out[i] & ~bus.port_dir[i] & ~bus.global_pullup_off);
      drive_en[i] = bus.ovr.direction_ovr_en[i] ? bus.ovr.direction_ovr_val[i]
                  : bus.port_dir[i];
      drive_val[i] = bus.ovr.outvalue_ovr_en[i] ? bus.ovr.outvalue_ovr_val[i]
                   : bus.port_out[i];
      toggle_req[i] = bus.ovr.toggle_ovr_en[i];
      // sleep gating of the buffer is outside this block, so default is on
      input_buf_on[i] = bus.ovr.input_enable_ovr_en[i] ? bus.ovr.input_enable_ovr_val[i]
                      : 1'b1;
    end
  end
endmodule // pdeo_pin_apply

/* pdeo_pin_sync.sv */
`timescale 1ns/10ps
module pdeo_pin_sync (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] pin_in,
  output logic [7:0]      pin_sync
);
  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } pdeo_sync_type;

  pdeo_sync_type state;
  pdeo_sync_type next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = pin_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= {pdeo_pkg::PORT_RESET, pdeo_pkg::PORT_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign pin_sync = state.stage2;
endmodule // pdeo_pin_sync

/* pdeo_checker.sv */
`timescale 1ns/10ps
module pdeo_checker (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] port_e_out,
  input wire logic [7:0] port_e_dir,
  input wire logic       global_pullup_off,
  input wire logic       clock_out_fuse,
  input wire logic       io_clock_div,
  input wire logic [7:0] pin_change_mask,
  input wire logic       pin_change_group0_en,
  input wire logic       two_wire_mode_sel,
  input wire logic       serial_if_data_out,
  input wire logic       clock_hold_low,
  input wire logic       clock_toggle_strobe,
  input wire logic       serial_sync_mode,
  input wire logic       transmitter_on,
  input wire logic       transmit_data,
  input wire logic       receiver_on,
  input wire logic [7:0] port_e_pullup_on,
  input wire logic [7:0] port_e_drive_en,
  input wire logic [7:0] port_e_drive_val,
  input wire logic [7:0] port_e_toggle_req,
  input wire logic [7:0] port_e_input_buf_on,
  input wire logic       serial_ext_clock_drive,
  input wire logic       divided_clock_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_clk_pin;
    clock_out_fuse |-> port_e_drive_en[7] && port_e_drive_val[7] == io_clock_div;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock pin not overridden");
  // reset must not stop the clock output, so this one ignores reset
  property p_clk_rst;
    disable iff (1'b0) !rst_n && clock_out_fuse |-> divided_clock_out == io_clock_div;
  endproperty
  a_clk_rst: assert property (p_clk_rst) else $error("clock output stopped in reset");
  property p_tx;
    transmitter_on |-> !port_e_pullup_on[1] && port_e_drive_en[1]
      && port_e_drive_val[1] == transmit_data;
  endproperty
  a_tx: assert property (p_tx) else $error("transmit pin wrong");
  property p_rx;
    receiver_on |-> !port_e_drive_en[0]
      && port_e_pullup_on[0] == (port_e_out[0] && !global_pullup_off);
  endproperty
  a_rx: assert property (p_rx) else $error("receive pin wrong");
  property p_sda;
    two_wire_mode_sel |-> !port_e_pullup_on[5] && !(port_e_dir[5] && port_e_drive_val[5])
      && port_e_drive_en[5] == (port_e_dir[5] && !(serial_if_data_out && port_e_out[5]));
  endproperty
  a_sda: assert property (p_sda) else $error("two wire data pin wrong");
  property p_scl;
    two_wire_mode_sel |-> !port_e_pullup_on[4] && port_e_toggle_req[4] == clock_toggle_strobe
      && port_e_drive_en[4] == (port_e_dir[4] && (clock_hold_low || !port_e_out[4]));
  endproperty
  a_scl: assert property (p_scl) else $error("two wire clock pin wrong");
  property p_pcbuf;
    pin_change_group0_en |-> &(port_e_input_buf_on | ~pin_change_mask);
  endproperty
  a_pcbuf: assert property (p_pcbuf) else $error("pin change buffer off");
  property p_xck;
    serial_sync_mode |-> serial_ext_clock_drive == port_e_dir[2];
  endproperty
  a_xck: assert property (p_xck) else $error("external clock role wrong");
  property p_xck_off;
    !serial_sync_mode |-> !serial_ext_clock_drive;
  endproperty
  a_xck_off: assert property (p_xck_off) else $error("external clock active in async");
endmodule // pdeo_checker
bind pdeo_top pdeo_checker i_pdeo_checker (.*);

/* pdeo_board.sv */
`timescale 1ns/10ps
module pdeo_board (
  input wire logic       core_clk,
  input wire logic [7:0] drive_en,
  input wire logic [7:0] drive_val,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0]     pin
);
  logic [7:0] float_pat = 8'h55;
  // an undriven pin without pull-up must never read as a steady level
  always @(posedge core_clk) float_pat <= ~float_pat;
  assign pin = (drive_en & drive_val) | (~drive_en & ext_en & ext_val)
             | (~drive_en & ~ext_en & (pullup_on | float_pat));
endmodule // pdeo_board

/* pdeo_top_tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", n, e, s); end end
module pdeo_top_tb;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] port_d_pin_in, port_d_out, port_d_dir, port_e_pin_in, port_e_out, port_e_dir;
  logic [7:0] pin_change_mask, d_ext_en, d_ext_val, e_ext_en, e_ext_val;
  logic global_pullup_off, ext_int0_en, clock_out_fuse, io_clock_div, pin_change_group0_en;
  logic three_wire_mode_sel, two_wire_mode_sel, serial_if_data_out, clock_hold_low;
  logic clock_toggle_strobe, start_cond_irq_en, serial_sync_mode, serial_ext_clock_out;
  logic transmitter_on, transmit_data, receiver_on, neg_in_digital_disable, pos_in_digital_disable;
  logic [7:0] port_d_pullup_on, port_d_drive_en, port_d_drive_val, port_d_input_buf_on;
  logic [7:0] port_d_in_sync, port_e_pullup_on, port_e_drive_en, port_e_drive_val;
  logic [7:0] port_e_toggle_req, port_e_input_buf_on, port_e_in_sync, pin_change_input;
  logic capture_input, ext_int0_input, serial_if_data_in, serial_if_clock, serial_ext_clock_in;
  logic serial_ext_clock_drive, receive_data_in, comparator_neg_sel, comparator_pos_sel;
  logic divided_clock_out;
  logic [3:0] k;
  int fails = 0, comparisons = 0, cycles = 0;
  pdeo_top i_pdeo_top (.*);
  pdeo_board i_pdeo_board_d (.core_clk, .drive_en(port_d_drive_en), .drive_val(port_d_drive_val),
    .pullup_on(port_d_pullup_on), .ext_en(d_ext_en), .ext_val(d_ext_val), .pin(port_d_pin_in));
  pdeo_board i_pdeo_board_e (.core_clk, .drive_en(port_e_drive_en), .drive_val(port_e_drive_val),
    .pullup_on(port_e_pullup_on), .ext_en(e_ext_en), .ext_val(e_ext_val), .pin(port_e_pin_in));
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_clk_out;
    clock_out_fuse = 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk) io_clock_div = i[0];
      if (i == 2) rst_n = 1'b1;
      #1 `CHK("div_clk", i[0], divided_clock_out)
      `CHK("pin7_drive", {1'b1, i[0]}, {port_e_drive_en[7], port_e_drive_val[7]})
    end
    @(negedge core_clk) clock_out_fuse = 1'b0;
    #1 `CHK("pin7_regs", 1'b0, port_e_drive_en[7])
  endtask
  task automatic t_sync;
    @(negedge core_clk) {d_ext_val, e_ext_val, ext_int0_en, receiver_on} = {8'h03, 8'h01, 2'h3};
    @(negedge core_clk) `CHK("capture_early", 1'b0, capture_input)
    @(negedge core_clk) `CHK("capture_in", 1'b1, capture_input)
    `CHK("int0_in", 1'b1, ext_int0_input)
    `CHK("rx_in", 1'b1, receive_data_in)
    `CHK("int0_buf", 1'b1, port_d_input_buf_on[1])
    `CHK("d_drive", {port_d_dir, port_d_out}, {port_d_drive_en, port_d_drive_val})
    `CHK("d_sync", 8'h03, port_d_in_sync)
    `CHK("pc_sync", 8'h01, pin_change_input)
    // registers alone must steer port D pins
    @(negedge core_clk) {port_d_dir, port_d_out} = 16'h0305;
    #1 `CHK("d_regs", 24'h030504, {port_d_drive_en, port_d_drive_val, port_d_pullup_on})
  endtask
  task automatic t_usart;
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk) {transmitter_on, port_e_dir, port_e_out} = {1'b1, 8'h01, 8'h01};
      {global_pullup_off, transmit_data} = 2'(i);
      #1 `CHK("tx_pullup", 1'b0, port_e_pullup_on[1])
      `CHK("tx_pin", {1'b1, i[0]}, {port_e_drive_en[1], port_e_drive_val[1]})
      `CHK("rx_dir", 1'b0, port_e_drive_en[0])
      `CHK("rx_pullup", ~i[1], port_e_pullup_on[0])
    end
    @(negedge core_clk) {receiver_on, transmitter_on, global_pullup_off} = 3'h0;
    #1 `CHK("rx_off_dir", 1'b1, port_e_drive_en[0])
  endtask
  task automatic t_two_wire;
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk) {two_wire_mode_sel, k} = {1'b1, 4'(i)};
      port_e_dir = {2'h0, k[0], k[0], 4'h0};
      port_e_out = {2'h0, k[1], k[2], 4'h0};
      {serial_if_data_out, clock_hold_low, clock_toggle_strobe} = {k[3], k[3], k[2]};
      #1 `CHK("pullup_5_4", 2'h0, port_e_pullup_on[5:4])
      `CHK("drive_en_5", k[0] & ~(k[3] & k[1]), port_e_drive_en[5])
      `CHK("drive_en_4", k[0] & (k[3] | ~k[2]), port_e_drive_en[4])
      `CHK("toggle_4", k[2], port_e_toggle_req[4])
      if (k[0]) `CHK("drive_val_5_4", 2'h0, port_e_drive_val[5:4])
    end
    @(negedge core_clk) {two_wire_mode_sel, three_wire_mode_sel} = 2'h1;
    for (int i = 0; i < 2; i++) begin
      @(negedge core_clk) serial_if_data_out = i[0];
      #1 `CHK("dout_6", i[0], port_e_drive_val[6])
    end
  endtask
  task automatic t_inbuf;
    {neg_in_digital_disable, pos_in_digital_disable, pin_change_group0_en} = 3'h7;
    serial_ext_clock_out = 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(negedge core_clk) pin_change_mask = (i == 8) ? 8'h00 : 8'h01 << i;
      #1 `CHK("in_buf", 8'hff & ~(8'h0c & ~pin_change_mask), port_e_input_buf_on)
    end
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk) {serial_sync_mode, port_e_dir} = {i[0], 5'h0, i[1], 2'h0};
      #1 `CHK("xck_drive", i[0] & i[1], serial_ext_clock_drive)
      `CHK("xck_pullup", i[0] & i[1], port_e_pullup_on[2])
    end
  endtask
  task automatic t_serial_in;
    @(negedge core_clk) {port_e_dir, e_ext_val, start_cond_irq_en, pin_change_group0_en} =
      {8'h00, 8'h34, 2'h2};
    repeat (2) @(negedge core_clk);
    `CHK("si_in", 2'h3, {serial_if_data_in, serial_if_clock})
    `CHK("start_buf", 2'h3, port_e_input_buf_on[5:4])
    `CHK("xck_in", 1'b1, serial_ext_clock_in)
    `CHK("cmp_sel", 2'h3, {comparator_neg_sel, comparator_pos_sel})
    // a mid-run reset must clear the synced inputs at once
    rst_n = 1'b0;
    #1 `CHK("pc_rst", 8'h00, pin_change_input)
    @(negedge core_clk) rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("pc_in", 8'h34, pin_change_input)
  endtask
  initial begin
    {port_d_out, port_d_dir, port_e_out, port_e_dir, pin_change_mask, d_ext_val, e_ext_val} = '0;
    {d_ext_en, e_ext_en} = 16'hffff;
    {global_pullup_off, ext_int0_en, clock_out_fuse, io_clock_div, pin_change_group0_en} = '0;
    {three_wire_mode_sel, two_wire_mode_sel, serial_if_data_out, clock_hold_low} = '0;
    {clock_toggle_strobe, start_cond_irq_en, serial_sync_mode, serial_ext_clock_out} = '0;
    {transmitter_on, transmit_data, receiver_on} = '0;
    {neg_in_digital_disable, pos_in_digital_disable} = '0;
    t_clk_out();
    t_sync();
    t_usart();
    t_two_wire();
    t_inbuf();
    t_serial_in();
    tally_and_finish();
  end
endmodule // pdeo_top_tb
